/* File: vectored_irq_source_control.sv */
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps
// What this block does
// RULE1 - runs on the free system clock; no power gating alters behaviour
// RULE2 - either processor request asserted also raises the wake-up output
// RULE3 - general mask keeps normal request off but still raises wake-up
// RULE4 - source 0 is fed only from the fast request input pin
// RULE5 - source 1 is the OR of all system peripheral interrupt lines
// RULE6 - sources 2 to 31 take a peripheral line or an external line
// RULE7 - per-source trigger field alone decides what counts as interrupt
// RULE8 - internal sources are level or edge; polarity has no meaning
// RULE9 - external sources: high level, low level, rising or falling edge
// RULE10 - enable and disable command writes of ones; mask is readable
// RULE11 - a disabled source never affects arbitration of enabled ones
// RULE12 - set command latches an edge source; clear command drops it
// RULE13 - set and clear leave level-sensitive sources unchanged
// RULE14 - software set behaves exactly like a detected hardware edge
// RULE15 - vector read clears only the current source's latched edge
// RULE16 - no automatic clear for sources with fast forcing enabled
// RULE17 - source 0 is cleared by a fast vector read instead
// RULE18 - pending status shows live activity, masked or not
// RULE19 - current number register returns the selected source number
// RULE20 - core image shows the normal and fast request line states
// RULE21 - external latency is equal with or without pin multiplexing
// RULE22 - sources 1 to 31 hold a priority 0 to 7, 7 highest
// RULE23 - equal top priority picks the smallest source number
// RULE24 - reading the vector register deasserts the normal request line
// RULE25 - external inputs are synchronised; edges compare to last sample
// RULE26 - software clears level sources at the originating peripheral
module vectored_irq_source_control #(
  parameter logic [31:0] EXT_MASK = 32'h0000_0001
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire irq_ctrl_pkg::apb_req_s apb_req_i,
  output irq_ctrl_pkg::apb_rsp_s apb_rsp_o,
  input wire logic fast_request_input_i,
  input wire logic [31:0] external_request_inputs_i,
  input wire logic [31:0] peripheral_irq_i,
  input wire logic [7:0] system_irq_i,
  input wire logic end_of_service_i,
  output logic normal_request_out_n_o,
  output logic fast_request_out_n_o,
  output logic wake_o,
  output logic vector_read_o,
  output logic fast_vector_read_o,
  output logic [4:0] current_source_o,
  output logic [2:0] current_level_o
);

  localparam int N = irq_ctrl_pkg::NUM_SRC;

  typedef struct packed {
    irq_ctrl_pkg::smr_s [N-1:0] smr;
    logic [31:0] mask;
    logic [31:0] force_fast;
    logic gen_mask;
    irq_ctrl_pkg::svc_e svc;
    logic [4:0] cur_src;
    logic [2:0] cur_lvl;
    logic [4:0] win_src;
    logic win_valid;
    logic irq_n;
    logic fiq_n;
    logic wake;
    logic vec_rd;
    logic fvec_rd;
    logic [31:0] prdata;
  } ctrl_s;

  ctrl_s r_reg;
  ctrl_s r_next;

  logic [31:0] raw_src;
  logic [31:0] active;
  logic [31:0] set_cmd;
  logic [31:0] clr_cmd;
  logic [31:0] cand;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic smr_hit;
  logic [4:0] smr_idx;
  logic mapped;
  logic found;
  logic [4:0] best_src;
  logic [2:0] best_prio;
  logic irq_cond;
  logic fiq_cond;
  logic irq_want;
  logic [31:0] rdata;

  // source map
  always_comb begin
    raw_src = '0;
    raw_src[0] = fast_request_input_i; // RULE4
    raw_src[1] = |system_irq_i; // RULE5
    for (int i = 2; i < N; i++) begin
      raw_src[i] = EXT_MASK[i] ? external_request_inputs_i[i]
                               : peripheral_irq_i[i]; // RULE6
    end
  end

  // one input stage per source; sync path same for every external line
  for (genvar g = 0; g < N; g++) begin : g_src
    irq_source_stage #(
      .EXTERNAL(g == 0 ? 1'b1 : (g == 1 ? 1'b0 : EXT_MASK[g])) // RULE21
    ) u_stage (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .raw_i(raw_src[g]),
      .trig_i(r_reg.smr[g].trig),
      .set_i(set_cmd[g]),
      .clr_i(clr_cmd[g]),
      .active_o(active[g])
    );
  end

  // apb decode
  always_comb begin
    setup = apb_req_i.psel & ~apb_req_i.penable;
    access = apb_req_i.psel & apb_req_i.penable;
    wr = access & apb_req_i.pwrite;
    rd = access & ~apb_req_i.pwrite;
    smr_hit = (apb_req_i.paddr <= irq_ctrl_pkg::OFS_SMR_LAST) &&
              (apb_req_i.paddr[1:0] == 2'h0);
    smr_idx = apb_req_i.paddr[6:2];
    case (apb_req_i.paddr)
      irq_ctrl_pkg::OFS_VECTOR,
      irq_ctrl_pkg::OFS_FAST_VECTOR,
      irq_ctrl_pkg::OFS_CUR_NUMBER,
      irq_ctrl_pkg::OFS_PENDING,
      irq_ctrl_pkg::OFS_MASK,
      irq_ctrl_pkg::OFS_CORE_IMAGE,
      irq_ctrl_pkg::OFS_ENABLE_CMD,
      irq_ctrl_pkg::OFS_DISABLE_CMD,
      irq_ctrl_pkg::OFS_CLEAR_CMD,
      irq_ctrl_pkg::OFS_SET_CMD,
      irq_ctrl_pkg::OFS_GEN_MASK,
      irq_ctrl_pkg::OFS_FAST_FORCE: mapped = 1'b1;
      default: mapped = smr_hit;
    endcase
  end

  // priority arbitration over enabled normal sources
  always_comb begin
    cand = active & r_reg.mask & ~r_reg.force_fast; // RULE11
    cand[0] = 1'b0;
    found = 1'b0;
    best_src = 5'h00;
    best_prio = 3'h0;
    // walk downward so that a tie leaves the smaller number
    for (int i = N - 1; i >= 1; i--) begin
      if (cand[i] && (!found || r_reg.smr[i].prio >= best_prio)) begin // RULE23
        found = 1'b1;
        best_src = 5'(i);
        best_prio = r_reg.smr[i].prio; // RULE22
      end
    end
    irq_cond = found;
    fiq_cond = (active[0] & r_reg.mask[0]) |
               (|(active & r_reg.mask & r_reg.force_fast));
  end

  // read data mux
  always_comb begin
    rdata = 32'h0000_0000;
    if (smr_hit) begin
      rdata[irq_ctrl_pkg::PRIO_LSB +: irq_ctrl_pkg::PRIO_W] =
        r_reg.smr[smr_idx].prio;
      rdata[irq_ctrl_pkg::TRIG_LSB +: irq_ctrl_pkg::TRIG_W] =
        r_reg.smr[smr_idx].trig;
    end
    case (apb_req_i.paddr)
      irq_ctrl_pkg::OFS_VECTOR: rdata = {27'h0, best_src};
      irq_ctrl_pkg::OFS_FAST_VECTOR: rdata = 32'h0000_0000;
      irq_ctrl_pkg::OFS_CUR_NUMBER: rdata = {27'h0, r_reg.cur_src}; // RULE19
      irq_ctrl_pkg::OFS_PENDING: rdata = active; // RULE18
      irq_ctrl_pkg::OFS_MASK: rdata = r_reg.mask; // RULE10
      irq_ctrl_pkg::OFS_CORE_IMAGE: begin
        rdata[irq_ctrl_pkg::IMG_IRQ_BIT] = ~r_reg.irq_n; // RULE20
        rdata[irq_ctrl_pkg::IMG_FIQ_BIT] = ~r_reg.fiq_n; // RULE20
      end
      irq_ctrl_pkg::OFS_GEN_MASK: rdata = {31'h0, r_reg.gen_mask};
      irq_ctrl_pkg::OFS_FAST_FORCE: rdata = r_reg.force_fast;
      default: rdata = rdata;
    endcase
  end

  // software set and clear plus automatic clears
  always_comb begin
    set_cmd = '0;
    clr_cmd = '0;
    if (wr && apb_req_i.paddr == irq_ctrl_pkg::OFS_SET_CMD) begin
      set_cmd = apb_req_i.pwdata; // RULE12
    end
    if (wr && apb_req_i.paddr == irq_ctrl_pkg::OFS_CLEAR_CMD) begin
      clr_cmd = apb_req_i.pwdata; // RULE12
    end
    if (rd && apb_req_i.paddr == irq_ctrl_pkg::OFS_VECTOR &&
        r_reg.win_valid && !r_reg.force_fast[r_reg.win_src]) begin // RULE16
      clr_cmd[r_reg.win_src] = 1'b1; // RULE15
    end
    if (rd && apb_req_i.paddr == irq_ctrl_pkg::OFS_FAST_VECTOR) begin
      clr_cmd[0] = 1'b1; // RULE17
    end
  end

  // next state
  always_comb begin
    r_next = r_reg;
    r_next.vec_rd = 1'b0;
    r_next.fvec_rd = 1'b0;
    // capture read data and winner in the setup cycle
    if (setup) begin
      r_next.prdata = rdata;
      r_next.win_src = best_src;
      r_next.win_valid = found;
    end
    if (wr) begin
      if (smr_hit) begin
        r_next.smr[smr_idx].prio =
          apb_req_i.pwdata[irq_ctrl_pkg::PRIO_LSB +: irq_ctrl_pkg::PRIO_W];
        r_next.smr[smr_idx].trig =
          apb_req_i.pwdata[irq_ctrl_pkg::TRIG_LSB +: irq_ctrl_pkg::TRIG_W];
      end
      case (apb_req_i.paddr)
        irq_ctrl_pkg::OFS_ENABLE_CMD:
          r_next.mask = r_reg.mask | apb_req_i.pwdata; // RULE10
        irq_ctrl_pkg::OFS_DISABLE_CMD:
          r_next.mask = r_reg.mask & ~apb_req_i.pwdata; // RULE10
        irq_ctrl_pkg::OFS_GEN_MASK:
          r_next.gen_mask = apb_req_i.pwdata[0];
        irq_ctrl_pkg::OFS_FAST_FORCE:
          r_next.force_fast = {apb_req_i.pwdata[31:1], 1'b0};
        default: r_next.mask = r_next.mask;
      endcase
    end
    // service tracking
    case (r_reg.svc)
      irq_ctrl_pkg::SVC_IDLE: begin
        if (end_of_service_i) begin
          r_next.svc = irq_ctrl_pkg::SVC_IDLE;
        end
      end
      irq_ctrl_pkg::SVC_BUSY: begin
        if (end_of_service_i) begin
          r_next.svc = irq_ctrl_pkg::SVC_IDLE;
        end
      end
      default: r_next.svc = irq_ctrl_pkg::SVC_IDLE;
    endcase
    if (rd && apb_req_i.paddr == irq_ctrl_pkg::OFS_VECTOR) begin
      r_next.vec_rd = 1'b1;
      if (r_reg.win_valid) begin
        r_next.svc = irq_ctrl_pkg::SVC_BUSY;
        r_next.cur_src = r_reg.win_src;
        r_next.cur_lvl = r_reg.smr[r_reg.win_src].prio;
      end
    end
    if (rd && apb_req_i.paddr == irq_ctrl_pkg::OFS_FAST_VECTOR) begin
      r_next.fvec_rd = 1'b1;
    end
    // normal request: idle, or a higher level than the one in service
    irq_want = irq_cond && (r_reg.svc == irq_ctrl_pkg::SVC_IDLE ||
                            best_prio > r_reg.cur_lvl);
    r_next.irq_n = ~(irq_want & ~r_reg.gen_mask); // RULE3
    if (rd && apb_req_i.paddr == irq_ctrl_pkg::OFS_VECTOR) begin
      r_next.irq_n = 1'b1; // RULE24
    end
    r_next.fiq_n = ~fiq_cond;
    // wake on any asserted line, or on a masked-off normal event
    r_next.wake = ~r_next.irq_n | ~r_next.fiq_n | // RULE2
                  (irq_want & r_reg.gen_mask); // RULE3
  end

  // state register on the free-running clock
  always_ff @(posedge clock_i) begin // RULE1
    if (sys_rst_i) begin
      r_reg <= '0;
      for (int i = 0; i < N; i++) begin
        r_reg.smr[i].trig <= irq_ctrl_pkg::RST_TRIG;
        r_reg.smr[i].prio <= irq_ctrl_pkg::RST_PRIO;
      end
      r_reg.mask <= irq_ctrl_pkg::RST_MASK;
      r_reg.force_fast <= irq_ctrl_pkg::RST_FORCE;
      r_reg.gen_mask <= irq_ctrl_pkg::RST_GEN_MASK;
      r_reg.svc <= irq_ctrl_pkg::SVC_IDLE;
      r_reg.irq_n <= 1'b1;
      r_reg.fiq_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs
  assign apb_rsp_o.prdata = r_reg.prdata;
  assign apb_rsp_o.pready = 1'b1;
  assign apb_rsp_o.pslverr = access & ~mapped;
  assign normal_request_out_n_o = r_reg.irq_n;
  assign fast_request_out_n_o = r_reg.fiq_n;
  assign wake_o = r_reg.wake;
  assign vector_read_o = r_reg.vec_rd;
  assign fast_vector_read_o = r_reg.fvec_rd;
  assign current_source_o = r_reg.cur_src;
  assign current_level_o = r_reg.cur_lvl;

endmodule // vectored_irq_source_control

/* File: irq_ctrl_pkg.sv */
package irq_ctrl_pkg;

  localparam int NUM_SRC = 32;
  localparam int ADDR_W = 12;

  // register byte offsets
  localparam logic [11:0] OFS_SMR_BASE = 12'h000;
  localparam logic [11:0] OFS_SMR_LAST = 12'h07c;
  localparam logic [11:0] OFS_VECTOR = 12'h100;
  localparam logic [11:0] OFS_FAST_VECTOR = 12'h104;
  localparam logic [11:0] OFS_CUR_NUMBER = 12'h108;
  localparam logic [11:0] OFS_PENDING = 12'h10c;
  localparam logic [11:0] OFS_MASK = 12'h110;
  localparam logic [11:0] OFS_CORE_IMAGE = 12'h114;
  localparam logic [11:0] OFS_ENABLE_CMD = 12'h120;
  localparam logic [11:0] OFS_DISABLE_CMD = 12'h124;
  localparam logic [11:0] OFS_CLEAR_CMD = 12'h128;
  localparam logic [11:0] OFS_SET_CMD = 12'h12c;
  localparam logic [11:0] OFS_GEN_MASK = 12'h130;
  localparam logic [11:0] OFS_FAST_FORCE = 12'h140;

  // source mode field layout
  localparam int PRIO_LSB = 0;
  localparam int PRIO_W = 3;
  localparam int TRIG_LSB = 5;
  localparam int TRIG_W = 2;
  // trigger field: bit 0 edge, bit 1 active high / rising
  localparam int TRIG_EDGE_BIT = 0;
  localparam int TRIG_POL_BIT = 1;
  localparam logic [1:0] TRIG_LOW_LEVEL = 2'h0;
  localparam logic [1:0] TRIG_FALL_EDGE = 2'h1;
  localparam logic [1:0] TRIG_HIGH_LEVEL = 2'h2;
  localparam logic [1:0] TRIG_RISE_EDGE = 2'h3;

  // core image bit positions
  localparam int IMG_IRQ_BIT = 1;
  localparam int IMG_FIQ_BIT = 0;

  // reset values
  localparam logic [1:0] RST_TRIG = 2'h0;
  localparam logic [2:0] RST_PRIO = 3'h0;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_FORCE = 32'h0000_0000;
  localparam logic RST_GEN_MASK = 1'b0;

  typedef struct packed {
    logic [TRIG_W-1:0] trig;
    logic [PRIO_W-1:0] prio;
  } smr_s;

  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_BUSY = 2'b01
  } svc_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic edge_latch;
  } stage_s;

endpackage

/* File: irq_source_stage.sv */
`timescale 1ns/10ps
module irq_source_stage #(
  parameter bit EXTERNAL = 1'b0
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic raw_i,
  input wire logic [1:0] trig_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic active_o
);

  irq_ctrl_pkg::stage_s st_reg;
  irq_ctrl_pkg::stage_s st_next;
  logic lvl;
  logic pol_high;
  logic hit;
  logic edge_mode;

  // detection and edge memory
  always_comb begin
    st_next = st_reg;
    st_next.sync1 = raw_i; // RULE25
    st_next.sync2 = st_reg.sync1; // RULE25
    lvl = EXTERNAL ? st_reg.sync2 : raw_i; // RULE25
    st_next.prev = lvl;
    // internal lines ignore polarity
    pol_high = EXTERNAL ? trig_i[irq_ctrl_pkg::TRIG_POL_BIT] : 1'b1; // RULE8
    edge_mode = trig_i[irq_ctrl_pkg::TRIG_EDGE_BIT]; // RULE7
    hit = pol_high ? (lvl & ~st_reg.prev) : (~lvl & st_reg.prev); // RULE9
    if (edge_mode) begin // RULE13
      if (clr_i) begin
        st_next.edge_latch = 1'b0; // RULE12
      end
      if (hit || set_i) begin
        st_next.edge_latch = 1'b1; // RULE14
      end
    end
    active_o = edge_mode ? st_reg.edge_latch : (pol_high ? lvl : ~lvl);
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule // irq_source_stage

/* File: irq_far_side.sv */
`timescale 1ns/10ps
// far side: pins, peripheral and system lines feeding the block
module irq_far_side (
  input wire logic clock_i,
  input wire logic normal_request_out_n_i,
  input wire logic fast_request_out_n_i,
  output logic fast_request_input_o,
  output logic [31:0] external_request_inputs_o,
  output logic [31:0] peripheral_irq_o,
  output logic [7:0] system_irq_o
);
  int core_takes;
  // idle lines: pins high, peripherals quiet
  initial begin
    fast_request_input_o = 1'b1;
    external_request_inputs_o = 32'hffff_ffff;
    peripheral_irq_o = 32'h0000_0000;
    system_irq_o = 8'h00;
    core_takes = 0;
  end
  // core side counts cycles with a request line low
  always @(posedge clock_i) begin
    if (!normal_request_out_n_i || !fast_request_out_n_i) core_takes++;
  end
  // change one line after dly edges, so answers come prompt or slow
  task automatic drive(input int kind, input int idx, input logic v,
                       input int dly);
    repeat (dly) @(posedge clock_i);
    case (kind)
      0: fast_request_input_o <= v;
      1: external_request_inputs_o[idx] <= v;
      2: peripheral_irq_o[idx] <= v; // handler clears at the source
      default: system_irq_o[idx[2:0]] <= v;
    endcase
  endtask
endmodule // irq_far_side

/* File: vectored_irq_source_control_props.sv */
`timescale 1ns/10ps
// watches request lines and the register bus of the block
module vectored_irq_source_control_props (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire irq_ctrl_pkg::apb_req_s apb_req_i,
  input wire irq_ctrl_pkg::apb_rsp_s apb_rsp_o,
  input wire logic normal_request_out_n_o,
  input wire logic fast_request_out_n_o,
  input wire logic wake_o,
  input wire logic vector_read_o,
  input wire logic fast_vector_read_o,
  input wire logic [4:0] current_source_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic acc, setup, vrd, frd, gm_reg;
  // bus phase decode
  assign acc = apb_req_i.psel && apb_req_i.penable;
  assign setup = apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite;
  assign vrd = acc && !apb_req_i.pwrite
    && apb_req_i.paddr == irq_ctrl_pkg::OFS_VECTOR;
  assign frd = acc && !apb_req_i.pwrite
    && apb_req_i.paddr == irq_ctrl_pkg::OFS_FAST_VECTOR;
  // shadow of the general mask bit
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) gm_reg <= 1'b0;
    else if (acc && apb_req_i.pwrite
      && apb_req_i.paddr == irq_ctrl_pkg::OFS_GEN_MASK)
      gm_reg <= apb_req_i.pwdata[0];
  end
  property p_wake;
    (!normal_request_out_n_o || !fast_request_out_n_o) |-> wake_o;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake low while a request line is low");
  property p_gmask;
    gm_reg |=> normal_request_out_n_o;
  endproperty
  a_gmask: assert property (p_gmask)
    else $error("normal line low under general mask");
  property p_vec_drop;
    vrd |=> normal_request_out_n_o && vector_read_o;
  endproperty
  a_vec_drop: assert property (p_vec_drop)
    else $error("normal line not released after vector read");
  property p_vec_once;
    vector_read_o |=> !vector_read_o;
  endproperty
  a_vec_once: assert property (p_vec_once)
    else $error("vector read pulse longer than one cycle");
  property p_fvr;
    frd |=> fast_vector_read_o ##1 !fast_vector_read_o;
  endproperty
  a_fvr: assert property (p_fvr)
    else $error("fast vector read pulse wrong");
  property p_cur;
    vrd && apb_rsp_o.prdata[4:0] != 5'h00
      |=> current_source_o == $past(apb_rsp_o.prdata[4:0]);
  endproperty
  a_cur: assert property (p_cur)
    else $error("current source differs from vector returned");
  property p_cur_read;
    setup && apb_req_i.paddr == irq_ctrl_pkg::OFS_CUR_NUMBER
      |=> apb_rsp_o.prdata == {27'h0, $past(current_source_o)};
  endproperty
  a_cur_read: assert property (p_cur_read)
    else $error("current number read wrong");
  property p_img;
    setup && apb_req_i.paddr == irq_ctrl_pkg::OFS_CORE_IMAGE
      |=> apb_rsp_o.prdata == {30'h0, !$past(normal_request_out_n_o),
        !$past(fast_request_out_n_o)};
  endproperty
  a_img: assert property (p_img)
    else $error("core image read wrong");
  property p_rst;
    $fell(sys_rst_i) |-> normal_request_out_n_o && fast_request_out_n_o
      && !wake_o;
  endproperty
  a_rst: assert property (p_rst)
    else $error("lines not idle after reset");
  c_vec: cover property (vrd ##1 vector_read_o);
  c_fvr: cover property (frd ##1 fast_vector_read_o);
  c_gm: cover property (gm_reg && wake_o && normal_request_out_n_o);
endmodule // vectored_irq_source_control_props

/* File: vectored_irq_source_control_bench.sv */
`timescale 1ns/10ps
module vectored_irq_source_control_bench;
  logic clock_i, sys_rst_i, end_of_service_i, err;
  logic fast_pin, normal_n, fast_n, wake;
  logic [31:0] ext, per, q;
  logic [7:0] system_source;
  logic [4:0] cur;
  logic [2:0] lvl;
  irq_ctrl_pkg::apb_req_s req;
  irq_ctrl_pkg::apb_rsp_s rsp;
  int fails = 0;
  int num_checks = 0;
  int mi[5] = '{5, 9, 6, 8, 0};
  logic [31:0] md[5] = '{32'h63, 32'h63, 32'h67, 32'h06, 32'h20};
  logic [11:0] ra[4] = '{irq_ctrl_pkg::OFS_MASK, irq_ctrl_pkg::OFS_CUR_NUMBER,
    irq_ctrl_pkg::OFS_CORE_IMAGE, irq_ctrl_pkg::OFS_FAST_FORCE};

  irq_far_side i_far (.clock_i(clock_i), .normal_request_out_n_i(normal_n),
    .fast_request_out_n_i(fast_n), .fast_request_input_o(fast_pin),
    .external_request_inputs_o(ext), .peripheral_irq_o(per),
    .system_irq_o(system_source));
  vectored_irq_source_control #(.EXT_MASK(32'h0000_0011)) i_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .apb_req_i(req),
    .apb_rsp_o(rsp), .fast_request_input_i(fast_pin),
    .external_request_inputs_i(ext), .peripheral_irq_i(per),
    .system_irq_i(system_source), .end_of_service_i(end_of_service_i),
    .normal_request_out_n_o(normal_n), .fast_request_out_n_o(fast_n),
    .wake_o(wake), .vector_read_o(), .fast_vector_read_o(),
    .current_source_o(cur), .current_level_o(lvl));

  // 100 MHz clock
  always #5 clock_i = ~clock_i;

  // compare tasks
  task automatic chk32(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk32(n, {31'h0, e}, {31'h0, g});
  endtask
  // one bus transfer: setup, then access held until pready
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge clock_i);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock_i);
    req.penable <= 1'b1;
    // only the watchdog ends a stuck access phase
    do begin
      @(posedge clock_i);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clock_i);
    #1;
  endtask
  task automatic eos();
    @(posedge clock_i);
    end_of_service_i <= 1'b1;
    @(posedge clock_i);
    end_of_service_i <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog far beyond the expected hundred and sixty or so cycles
  initial begin
    repeat (5000) @(posedge clock_i);
    fails++;
    wrap_up();
  end

  // main sequence
  initial begin
    clock_i = 1'b0;
    sys_rst_i = 1'b1;
    end_of_service_i = 1'b0;
    req = '0;
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk32("reset value", 32'h0, q);
    end
    // modes, then enable with a stray bit that is disabled again
    foreach (mi[i]) wr(12'(mi[i] * 4), md[i]);
    wr(irq_ctrl_pkg::OFS_ENABLE_CMD, 32'h0000_0327);
    wr(irq_ctrl_pkg::OFS_DISABLE_CMD, 32'h0000_0004);
    rd(irq_ctrl_pkg::OFS_MASK);
    chk32("mask", 32'h0000_0323, q);
    // two equal levels set, plus a disabled top level
    wr(irq_ctrl_pkg::OFS_SET_CMD, 32'h0000_0260);
    wt(2);
    chk1("normal line", 1'b0, normal_n);
    chk1("wake", 1'b1, wake);
    rd(irq_ctrl_pkg::OFS_PENDING);
    chk32("pending", 32'h0000_0260, q);
    rd(irq_ctrl_pkg::OFS_VECTOR);
    chk32("vector", 32'h5, q);
    wt(2);
    chk1("normal line", 1'b1, normal_n);
    rd(irq_ctrl_pkg::OFS_CUR_NUMBER);
    chk32("current", 32'h5, q);
    wr(irq_ctrl_pkg::OFS_CLEAR_CMD, 32'h0000_0040);
    rd(irq_ctrl_pkg::OFS_PENDING);
    chk32("pending", 32'h0000_0200, q);
    eos();
    rd(irq_ctrl_pkg::OFS_VECTOR);
    chk32("vector", 32'h9, q);
    // level source: the clear command leaves it, the peripheral drops it
    i_far.drive(2, 8, 1'b1, 1);
    wt(2);
    rd(irq_ctrl_pkg::OFS_VECTOR);
    chk32("vector", 32'h8, q);
    wt(1);
    chk32("level", 32'h6, {29'h0, lvl});
    chk32("current out", 32'h8, {27'h0, cur});
    wr(irq_ctrl_pkg::OFS_CLEAR_CMD, 32'h0000_0100);
    rd(irq_ctrl_pkg::OFS_PENDING);
    chk32("pending", 32'h0000_0100, q);
    i_far.drive(2, 8, 1'b0, 1);
    eos();
    rd(irq_ctrl_pkg::OFS_PENDING);
    chk32("pending", 32'h0, q);
    // falling edge on the fast pin
    i_far.drive(0, 0, 1'b0, 1);
    wt(6);
    chk1("fast line", 1'b0, fast_n);
    chk1("wake", 1'b1, wake);
    rd(irq_ctrl_pkg::OFS_CORE_IMAGE);
    chk32("image", 32'h1, q);
    rd(irq_ctrl_pkg::OFS_FAST_VECTOR);
    rd(irq_ctrl_pkg::OFS_PENDING);
    chk32("pending", 32'h0, q);
    chk1("fast line", 1'b1, fast_n);
    // general mask: wake without the normal line
    wr(irq_ctrl_pkg::OFS_GEN_MASK, 32'h1);
    wr(irq_ctrl_pkg::OFS_SET_CMD, 32'h0000_0020);
    wt(3);
    chk1("normal line", 1'b1, normal_n);
    chk1("wake", 1'b1, wake);
    wr(irq_ctrl_pkg::OFS_GEN_MASK, 32'h0);
    wt(2);
    chk1("normal line", 1'b0, normal_n);
    rd(irq_ctrl_pkg::OFS_VECTOR);
    chk32("vector", 32'h5, q);
    eos();
    // fast forcing: source 9 moves to the fast line, no auto clear
    wr(irq_ctrl_pkg::OFS_FAST_FORCE, 32'h0000_0201);
    wr(irq_ctrl_pkg::OFS_SET_CMD, 32'h0000_0200);
    wt(2);
    chk1("fast line", 1'b0, fast_n);
    chk1("normal line", 1'b1, normal_n);
    rd(irq_ctrl_pkg::OFS_FAST_FORCE);
    chk32("force", 32'h0000_0200, q);
    rd(irq_ctrl_pkg::OFS_VECTOR);
    chk32("vector", 32'h0, q);
    rd(irq_ctrl_pkg::OFS_PENDING);
    chk32("pending", 32'h0000_0200, q);
    wr(irq_ctrl_pkg::OFS_CLEAR_CMD, 32'h0000_0200);
    wr(irq_ctrl_pkg::OFS_FAST_FORCE, 32'h0);
    wt(2);
    chk1("fast line", 1'b1, fast_n);
    // external high level and a system line
    wr(12'h010, 32'h40);
    i_far.drive(3, 3, 1'b1, 1);
    wt(4);
    rd(irq_ctrl_pkg::OFS_PENDING);
    chk32("pending", 32'h0000_0012, q);
    rd(12'h200);
    chk1("slave error", 1'b1, err);
    chk32("unmapped data", 32'h0, q);
    chk1("core requests", 1'b1, i_far.core_takes > 0);
    wrap_up();
  end
endmodule // vectored_irq_source_control_bench

bind vectored_irq_source_control vectored_irq_source_control_props i_props (
  .clock_i, .sys_rst_i, .apb_req_i, .apb_rsp_o, .normal_request_out_n_o,
  .fast_request_out_n_o, .wake_o, .vector_read_o, .fast_vector_read_o,
  .current_source_o);
